// ==== fwsr_host.v ====
// host side status checker for a banked flash program or erase
`timescale 1ns/100ps
`include "fwsr_regs.vh"
// Behaviour
// RULE_01 - poll bit inverse while program runs
// RULE_02 - poll bit true after program ends
// RULE_03 - protected program target: status about 1 us
// RULE_04 - erase: poll low, high when done
// RULE_05 - all protected erase: status about 100 us
// RULE_06 - protected sectors silently skipped in erase
// RULE_07 - host polls at program or erase address
// RULE_08 - status valid after final write pulse
// RULE_09 - after poll flip, trust later reads only
// RULE_10 - ready busy low while programming or erasing
// RULE_11 - ready busy is open drain, shared
// RULE_12 - toggle one inverts per read while busy
// RULE_13 - toggle one toggles in erase time-out
// RULE_14 - all protected erase toggles about 100 us
// RULE_15 - protected program toggles about 1 us
// RULE_16 - toggle one stops in erase suspend
// RULE_17 - toggle two toggles in erasing sectors
// RULE_18 - host reads twice, compares toggle bit
// RULE_19 - toggling with timeout: recheck, else fail
// RULE_20 - host rechecks poll bit after timeout
// RULE_21 - interrupted check restarts from the top
// RULE_22 - timeout flag marks failed operation
// RULE_23 - host addresses the busy bank
// RULE_24 - toggle two steady in program, toggles erase
// RULE_25 - toggle bits flip per read to busy bank
module fwsr_host (
  core_clk,
  reset,
  check_start,
  check_abort,
  use_poll,
  status_addr,
  expect_data,
  check_busy,
  check_done,
  check_result,
  final_data,
  erase_suspended,
  erase_started,
  rb_busy,
  flash_addr,
  flash_ce_n,
  flash_oe_n,
  flash_we_n,
  flash_dq_in,
  flash_dq_oe_n,
  flash_ready_busy_n
);
  input wire core_clk;
  input wire reset;
  input wire check_start;
  input wire check_abort;
  input wire use_poll;
  input wire [21:0] status_addr;
  input wire [7:0] expect_data;
  output wire check_busy;
  output reg check_done;
  output reg [1:0] check_result;
  output reg [15:0] final_data;
  output reg erase_suspended;
  output reg erase_started;
  output wire rb_busy;
  output wire [21:0] flash_addr;
  output wire flash_ce_n;
  output wire flash_oe_n;
  output wire flash_we_n;
  input wire [15:0] flash_dq_in;
  output wire flash_dq_oe_n;
  input wire flash_ready_busy_n;

  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam [2:0] st_idle = 3'h0;
  localparam [2:0] st_first = 3'h1;
  localparam [2:0] st_second = 3'h2;
  localparam [2:0] st_recheck = 3'h3;
  localparam [2:0] st_data = 3'h4;
  localparam [2:0] st_finish = 3'h5;

  reg [2:0] state;
  reg [2:0] next_state;
  reg [2:0] rb_sync;
  reg rb_low;
  reg [21:0] addr_hold;
  reg [7:0] expect_hold;
  reg poll_mode;
  reg [15:0] prev_word;
  reg [1:0] next_result;
  reg next_fin;
  reg rd_start;
  reg rd_pending;
  wire rd_done;
  wire [15:0] rd_data;

  // a bit toggles between two consecutive reads
  function toggled;
    input [15:0] a;
    input [15:0] b;
    begin
      toggled = (a[`FWSR_TOGGLE_ONE_BIT] != b[`FWSR_TOGGLE_ONE_BIT]);
    end
  endfunction

  // poll bit shows written data in the given word
  function poll_true;
    input [15:0] w;
    input [7:0] exp;
    begin
      poll_true = (w[`FWSR_POLL_BIT] == exp[`FWSR_POLL_BIT]);
    end
  endfunction

  // ----------------------------------------
  // pins
  // ----------------------------------------
  // host only reads, never drives data or writes
  assign flash_we_n = 1'b1;
  assign flash_dq_oe_n = 1'b1;
  assign check_busy = (state != st_idle);
  assign rb_busy = rb_low;

  fwsr_read_cycle u_read (
    .core_clk(core_clk),
    .reset(reset),
    .start(rd_start),
    .addr(addr_hold),
    .done(rd_done),
    .rdata(rd_data),
    .flash_addr(flash_addr),
    .flash_ce_n(flash_ce_n),
    .flash_oe_n(flash_oe_n),
    .flash_dq_in(flash_dq_in)
  );

  // shared open drain busy line, three stage synchroniser
  always @(posedge core_clk) begin
    if (reset) begin
      rb_sync <= 3'h7;
      rb_low <= 1'b0;
    end else begin
      rb_sync <= {rb_sync[1:0], flash_ready_busy_n}; // RULE_11
      if (rb_sync[1] == rb_sync[2]) begin
        rb_low <= ~rb_sync[2]; // RULE_10
      end
    end
  end

  // ----------------------------------------
  // status check sequence
  // ----------------------------------------
  // next state from each completed read
  always @* begin
    next_state = state;
    next_result = `FWSR_RES_OK;
    next_fin = 1'b0;
    case (state)
      st_idle: begin
        if (check_start) begin
          next_state = st_first; // RULE_08
        end
      end
      st_first: begin
        if (rd_done) begin
          next_state = st_second; // RULE_18
        end
      end
      st_second: begin
        if (rd_done) begin
          if (poll_mode) begin
            if (poll_true(rd_data, expect_hold)) begin
              next_state = st_data; // RULE_09
            end else if (rd_data[`FWSR_TIMEOUT_BIT]) begin
              next_state = st_recheck; // RULE_20
            end else begin
              next_state = st_second; // RULE_01
            end
          end else if (!toggled(prev_word, rd_data)) begin
            next_state = st_data; // RULE_18
          end else if (rd_data[`FWSR_TIMEOUT_BIT]) begin
            next_state = st_recheck; // RULE_19
          end else begin
            next_state = st_second; // RULE_12
          end
        end
      end
      st_recheck: begin
        if (rd_done) begin
          next_state = st_finish;
          next_fin = 1'b1;
          if (poll_mode) begin
            next_result = poll_true(rd_data, expect_hold) ? `FWSR_RES_OK : `FWSR_RES_FAIL;
          end else begin
            next_result = toggled(prev_word, rd_data) ? `FWSR_RES_FAIL : `FWSR_RES_OK;
          end
          if (next_result == `FWSR_RES_OK) begin
            next_state = st_data; // RULE_09
            next_fin = 1'b0;
          end
        end
      end
      st_data: begin
        if (rd_done) begin
          next_state = st_finish;
          next_fin = 1'b1;
        end
      end
      st_finish: begin
        if (!rd_pending) begin
          next_state = st_idle; // RULE_21
        end
      end
      default: begin
        next_state = st_idle;
      end
    endcase
  end

  // a read still on the pins after an abort keeps the check busy until it ends
  always @(posedge core_clk) begin
    if (reset) begin
      rd_pending <= 1'b0;
    end else if (rd_start) begin
      rd_pending <= 1'b1;
    end else if (rd_done) begin
      rd_pending <= 1'b0;
    end
  end

  // sequence registers; abort drops the check so a retry starts over
  always @(posedge core_clk) begin
    check_done <= 1'b0;
    rd_start <= 1'b0;
    if (reset) begin
      state <= st_idle;
      addr_hold <= 22'h000000;
      expect_hold <= 8'h00;
      poll_mode <= 1'b0;
      prev_word <= 16'h0000;
      check_result <= `FWSR_RES_OK;
      final_data <= 16'h0000;
      erase_suspended <= 1'b0;
      erase_started <= 1'b0;
    end else if (check_abort && check_busy) begin
      state <= st_finish; // RULE_21
      check_done <= 1'b1;
      check_result <= `FWSR_RES_ABORT;
    end else begin
      state <= next_state;
      if (state == st_idle && check_start) begin
        addr_hold <= status_addr; // RULE_07 RULE_23
        expect_hold <= expect_data;
        poll_mode <= use_poll;
        rd_start <= 1'b1;
      end
      if (rd_done) begin
        prev_word <= rd_data;
        if (state == st_second) begin
          // toggle two moving while toggle one holds means suspended sector
          erase_suspended <= !toggled(prev_word, rd_data)
            && (prev_word[`FWSR_TOGGLE_TWO_BIT] != rd_data[`FWSR_TOGGLE_TWO_BIT]); // RULE_17
          erase_started <= rd_data[`FWSR_ERASE_TIMER_BIT];
        end
        if (state == st_data) begin
          final_data <= rd_data; // RULE_09
        end
        // no new read for an orphan read that ends after an abort
        if (state != st_idle && state != st_finish && next_state != st_finish) begin
          rd_start <= 1'b1;
        end
      end
      if (next_fin) begin
        check_done <= 1'b1;
        check_result <= (state == st_data) ? `FWSR_RES_OK : next_result; // RULE_22
      end
    end
  end
endmodule // fwsr_host

// ==== fwsr_regs.vh ====
// constants for the flash write status host controller
`ifndef FWSR_REGS_VH
`define FWSR_REGS_VH
// ----------------------------------------
// data bus status bit positions
// ----------------------------------------
`define FWSR_POLL_BIT 7
`define FWSR_TOGGLE_ONE_BIT 6
`define FWSR_TIMEOUT_BIT 5
`define FWSR_ERASE_TIMER_BIT 3
`define FWSR_TOGGLE_TWO_BIT 2
// ----------------------------------------
// pin read cycle timing
// ----------------------------------------
`define FWSR_CLK_PERIOD_NS 10
`define FWSR_READ_ACCESS_NS 70
`define FWSR_READ_ACCESS_CYC ((`FWSR_READ_ACCESS_NS + `FWSR_CLK_PERIOD_NS - 1) / `FWSR_CLK_PERIOD_NS)
`define FWSR_READ_GAP_CYC 2
// ----------------------------------------
// result codes
// ----------------------------------------
`define FWSR_RES_OK 2'h0
`define FWSR_RES_FAIL 2'h1
`define FWSR_RES_ABORT 2'h2
`endif

// ==== fwsr_read_cycle.v ====
// one asynchronous parallel read cycle on the flash pins
`timescale 1ns/100ps
`include "fwsr_regs.vh"
module fwsr_read_cycle (
  core_clk,
  reset,
  start,
  addr,
  done,
  rdata,
  flash_addr,
  flash_ce_n,
  flash_oe_n,
  flash_dq_in
);
  input wire core_clk;
  input wire reset;
  input wire start;
  input wire [21:0] addr;
  output reg done;
  output reg [15:0] rdata;
  output reg [21:0] flash_addr;
  output reg flash_ce_n;
  output reg flash_oe_n;
  input wire [15:0] flash_dq_in;

  localparam integer access_int = `FWSR_READ_ACCESS_CYC;
  localparam integer gap_int = `FWSR_READ_GAP_CYC;
  localparam [7:0] access_cyc = access_int[7:0]; // counts stay far below 256
  localparam [7:0] gap_cyc = gap_int[7:0];
  reg [7:0] count;
  reg phase_active;
  reg phase_gap;

  // strobe low for access time, sample, then hold high for recovery
  always @(posedge core_clk) begin
    done <= 1'b0;
    if (reset) begin
      count <= 8'h00;
      phase_active <= 1'b0;
      phase_gap <= 1'b0;
      flash_ce_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_addr <= 22'h000000;
      rdata <= 16'h0000;
    end else if (phase_active) begin
      if (count == access_cyc) begin
        rdata <= flash_dq_in; // data registered at end of access
        flash_ce_n <= 1'b1;
        flash_oe_n <= 1'b1; // rising oe ends the read cycle
        phase_active <= 1'b0;
        phase_gap <= 1'b1;
        count <= 8'h00;
      end else begin
        count <= count + 8'h01;
      end
    end else if (phase_gap) begin
      if (count == gap_cyc) begin
        phase_gap <= 1'b0;
        done <= 1'b1;
      end else begin
        count <= count + 8'h01;
      end
    end else if (start) begin
      flash_addr <= addr;
      flash_ce_n <= 1'b0;
      flash_oe_n <= 1'b0;
      phase_active <= 1'b1;
      count <= 8'h01;
    end
  end
endmodule // fwsr_read_cycle

// ==== fwsr_assertions.sv ====
// port checker for the flash status host
`timescale 1ns/100ps
module fwsr_checker (
  input wire core_clk,
  input wire reset,
  input wire check_start,
  input wire check_abort,
  input wire check_busy,
  input wire check_done,
  input wire [1:0] check_result,
  input wire rb_busy,
  input wire [21:0] status_addr,
  input wire [21:0] flash_addr,
  input wire flash_ce_n,
  input wire flash_oe_n,
  input wire flash_we_n,
  input wire flash_dq_oe_n,
  input wire flash_ready_busy_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  int nrd;
  // reads issued by the current check
  always @(posedge core_clk)
    if (reset || (check_start && !check_busy)) nrd <= 0;
    else if ($fell(flash_oe_n)) nrd <= nrd + 1;
  chk_done_pulse: assert property (
    check_done |=> !check_done) else $error("done too long");
  chk_min_reads: assert property (
    check_done && check_result != 2'h2 |-> nrd >= 3) else $error("too few reads");
  chk_read_len: assert property (
    $fell(flash_oe_n) |-> !flash_oe_n [*7]) else $error("read strobe short");
  chk_read_gap: assert property (
    $rose(flash_oe_n) |-> flash_oe_n [*2]) else $error("read gap short");
  chk_start_go: assert property (
    check_start && !check_busy |=> check_busy) else $error("start lost");
  chk_abort_stop: assert property (
    check_busy && check_abort |-> ##[1:2] check_done && check_result == 2'h2)
    else $error("abort late");
  chk_idle_quiet: assert property (
    !check_busy [*2] |-> flash_ce_n && flash_oe_n) else $error("read while idle");
  chk_addr_held: assert property (
    !flash_ce_n |-> flash_addr == status_addr) else $error("wrong status address");
  chk_never_drive: assert property (
    flash_dq_oe_n && flash_we_n) else $error("host drives bus");
  chk_rb_low: assert property (
    !flash_ready_busy_n [*4] |=> rb_busy) else $error("busy not seen");
  chk_rb_high: assert property (
    flash_ready_busy_n [*4] |=> !rb_busy) else $error("ready not seen");
  cover property (check_done && check_result == 2'h0);
  cover property (check_done && check_result == 2'h1);
  cover property (check_done && check_result == 2'h2);
endmodule // fwsr_checker

// ==== fwsr_flash_model.sv ====
// flash device model answering status reads
`timescale 1ns/100ps
module fwsr_flash_model (
  input wire ce_n,
  input wire oe_n,
  output wire [15:0] dq,
  output wire ready_busy_n
);
  logic t1 = 0, t2 = 0, erase = 0, susp = 0, tmo = 0;
  logic [7:0] pb = 8'h00;
  logic [15:0] arr = 16'h0000, last = 16'h0000;
  int left = 0;
  wire busy = left > 0;
  wire sel = !ce_n && !oe_n;
  // status word while the algorithm runs
  wire [15:0] stat = {8'h00, erase ? susp : ~pb[7], t1, tmo, 1'b0, erase, t2, 2'h0};
  // open drain busy line, released in suspend
  assign ready_busy_n = busy && !susp ? 1'b0 : 1'bz;
  // selected word; released bus shows its inverse
  always @* if (sel) last = busy ? stat : arr;
  assign dq = sel ? last : ~last;
  // end of each read cycle advances the algorithm
  always @(negedge sel) if (busy) begin
    t1 <= susp ? t1 : ~t1;
    t2 <= erase ? ~t2 : t2;
    left <= susp ? left : left - 1;
  end
endmodule // fwsr_flash_model

// ==== tb_flash_write_status_reporting.sv ====
// self-checking bench for the flash status host
`timescale 1ns/100ps
`include "fwsr_regs.vh"
module tb_flash_write_status_reporting;
  logic core_clk = 0, reset = 1, check_start = 0, check_abort = 0, use_poll = 0;
  logic [21:0] status_addr = 22'h0, flash_addr;
  logic [7:0] expect_data = 8'h00;
  logic check_busy, check_done, erase_suspended, erase_started, rb_busy;
  logic flash_ce_n, flash_oe_n, flash_we_n, flash_dq_oe_n;
  logic [1:0] check_result;
  logic [15:0] final_data, flash_dq_in;
  wire flash_ready_busy_n;
  int bad_count = 0, compares = 0, cyc = 0;
  pullup (flash_ready_busy_n);
  always #5 core_clk = ~core_clk;
  fwsr_host dut (.core_clk, .reset, .check_start, .check_abort, .use_poll,
    .status_addr, .expect_data, .check_busy, .check_done, .check_result,
    .final_data, .erase_suspended, .erase_started, .rb_busy, .flash_addr,
    .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_dq_in, .flash_dq_oe_n,
    .flash_ready_busy_n);
  fwsr_flash_model m (.ce_n(flash_ce_n), .oe_n(flash_oe_n), .dq(flash_dq_in),
    .ready_busy_n(flash_ready_busy_n));
  task chk(input logic [15:0] s, input logic [15:0] e);
    compares++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %0t got %h want %h", $time, s, e);
    end
  endtask
  task summarize;
    $display("mismatches %0d compares %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      summarize;
    end
  end
  // one status check against the model: poll, erase, suspend, timeout, abort
  task automatic run(input bit p, e, s, t, a, input int n);
    logic [1:0] xr;
    int k;
    while (check_busy !== 1'b0) @(posedge core_clk) #1;
    xr = a ? `FWSR_RES_ABORT : t ? `FWSR_RES_FAIL : `FWSR_RES_OK;
    m.erase = e;
    m.susp = s;
    m.tmo = t;
    m.left = n;
    m.pb = e ? 8'hff : 8'($urandom);
    m.arr = e ? 16'hffff : {8'($urandom), m.pb};
    use_poll = p;
    expect_data = m.pb;
    check_start = 1;
    @(posedge core_clk) #1;
    check_start = 0;
    k = 0;
    while (check_done !== 1'b1) begin
      check_abort = a && k == 20;
      if (k == 25) chk(rb_busy, m.left > 0 && !s);
      @(posedge core_clk) #1;
      k++;
    end
    check_abort = 0;
    chk(check_result, xr);
    if (!a) chk(erase_started, (s || t) ? e : m.arr[3]);
    if (!s && !t && !a) chk(final_data, m.arr);
    if (!p && !t && !a && (s || n == 0)) chk(erase_suspended, s);
    m.left = 0; // reset command ends a failed or suspended operation
    m.susp = 0;
    repeat (5) @(posedge core_clk);
    #1 chk(rb_busy, 0);
  endtask
  initial begin
    void'($urandom(75));
    status_addr = 22'($urandom);
    repeat (2) @(posedge core_clk);
    #1 reset = 0;
    run(0, 0, 0, 0, 0, 4);
    run(1, 0, 0, 0, 0, 4);
    run(1, 1, 0, 0, 0, 5);
    run(0, 1, 0, 0, 0, 6);
    run(0, 0, 0, 1, 0, 99999);
    run(1, 1, 0, 1, 0, 99999);
    run(0, 1, 1, 0, 0, 3);
    run(0, 0, 0, 0, 1, 99999);
    for (int i = 0; i < 6; i++)
      run(1'($urandom), 1'($urandom), 0, 0, 0, $urandom % 8);
    summarize;
  end
endmodule // tb_flash_write_status_reporting
bind fwsr_host fwsr_checker chk_i (.core_clk, .reset, .check_start, .check_abort,
  .check_busy, .check_done, .check_result, .rb_busy, .status_addr, .flash_addr,
  .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_dq_oe_n, .flash_ready_busy_n);
